// ===== design/beis_pkg.sv
// Package of constants for the bridge error interrupt status block.
package beis_pkg;

   // ==========================================================
   // Register map
   localparam logic [11:0] BEIS_ERR_STATUS_OFF = 12'h414;
   localparam logic [11:0] BEIS_ERR_MASK_OFF = 12'h420;
   localparam logic [11:0] BEIS_NORM_STATUS_OFF = 12'h410;
   localparam logic [31:0] BEIS_RESET_VAL = 32'h00000000;

   // ==========================================================
   // Field positions in the error status register
   localparam int BEIS_NORM_ACTIVE_BIT = 31;
   localparam int BEIS_PB_RETRY_FIRST_BIT = 27;
   localparam int BEIS_PB_RETRY_SECOND_BIT = 26;
   localparam int BEIS_PB_RETRY_LOCAL_BIT = 25;
   localparam int BEIS_PB_ERR_FIRST_BIT = 23;
   localparam int BEIS_PB_ERR_SECOND_BIT = 22;
   localparam int BEIS_PB_ERR_LOCAL_BIT = 21;
   localparam int BEIS_PB_APAR_BIT = 20;
   localparam int BEIS_PB_DPAR_FIRST_BIT = 19;
   localparam int BEIS_PB_DPAR_SECOND_BIT = 18;
   localparam int BEIS_PB_DPAR_LOCAL_BIT = 17;
   localparam int BEIS_SECOND_PCI_LSB = 8;
   localparam int BEIS_FIRST_PCI_LSB = 0;

   // Writable flag positions with both PCI ports present.
   localparam logic [31:0] BEIS_FLAG_MASK_DUAL = 32'h0EFEFEFE;
   // Flags that belong to the second PCI port.
   localparam logic [31:0] BEIS_SECOND_PCI_MASK = 32'h0444FE88;
   // Normal status register is software visible except bit 30.
   localparam logic [31:0] BEIS_NORM_FLAG_MASK = 32'hBFFFFFFF;

endpackage : beis_pkg

// ===== design/beis_flag_bank.sv
// Sticky write-one-to-clear flag bank with set-over-clear priority.
`timescale 1ns/10ps
`default_nettype none
module beis_flag_bank
   import beis_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] valid_in,
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clear_in,
   output logic [WIDTH-1:0] flags_out
);

   // ==========================================================
   // Elaboration check
   if (WIDTH < 1) begin : g_width_check
      $error("beis_flag_bank width must be positive");
   end

   logic [WIDTH-1:0] flags_ff;
   logic [WIDTH-1:0] nxt_flags;

   // ==========================================================
   // Flag update
   always_comb begin
      // A new event outweighs a clear in the same cycle.
      nxt_flags = ((flags_ff & ~clear_in) | set_in) & valid_in;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   assign flags_out = flags_ff;

endmodule : beis_flag_bank
`default_nettype wire

// ===== design/beis_error_status.sv
// Error interrupt status register with normal status companion, mask and APB slave.
// ==========================================================
// Summary of operation
// - Error flags sit by byte: retry flags and summary on top, bus errors and parity next, then PCI-2, then PCI-1, bit 0 of each byte zero.
// - A read-only summary bit in the top byte shows whether any normal status bit is set.
// - Processor-bus max-retry flags are set separately for PCI-1 and PCI-2 as the other side.
// - A separate processor-bus max-retry flag covers processor-bus to processor-bus DMA.
// - Processor-bus transfer error flags are kept per PCI-1, PCI-2 and local DMA.
// - One processor-bus address parity flag is sticky until written with one and cleared by reset.
// - Processor-bus data parity flags are kept separately for PCI-1 and PCI-2 as the other side.
// - A separate processor-bus data parity flag covers processor-bus local DMA.
// - PCI-2 error flags are kept for PCI-1 and processor-bus cycles, and software reads the PCI-2 status for the cause.
// - A distinct PCI-2 error flag covers PCI-2 to PCI-2 DMA.
// - One PCI-2 address parity flag is sticky until written with one and cleared by reset.
// - PCI-2 master excessive-retry flags are kept per PCI-1, processor bus and local DMA origin.
// - In the single-PCI variant every flag of the second PCI port is reserved.
// - PCI-1 error flags sit in the lowest byte, and software reads the PCI-1 status for the cause.
// - PCI-1 master excessive-retry flags are kept per starting side of the cycle.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module beis_error_status
   import beis_pkg::*;
#(
   parameter bit SINGLE_PCI = 1'b0
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [31:0] normal_event_in,
   input wire logic [2:0] procbus_maxretry_in,
   input wire logic [2:0] procbus_xfer_error_in,
   input wire logic procbus_addr_parity_error_in,
   input wire logic [2:0] procbus_data_parity_in,
   input wire logic [2:0] second_pci_error_in,
   input wire logic second_pci_addr_parity_error_in,
   input wire logic [2:0] second_pci_retry_in,
   input wire logic [2:0] first_pci_error_in,
   input wire logic first_pci_addr_parity_error_in,
   input wire logic [2:0] first_pci_retry_in,
   output logic irq_out
);

   // ==========================================================
   // Event assembly
   logic [31:0] err_valid;
   logic [31:0] err_set;
   logic [31:0] err_clear;
   logic [31:0] err_flags;
   logic [31:0] norm_set;
   logic [31:0] norm_clear;
   logic [31:0] norm_flags;
   logic normal_status_any_active;

   // Two-PCI parts use every flag; single-PCI parts drop the second port.
   assign err_valid = SINGLE_PCI ? (BEIS_FLAG_MASK_DUAL & ~BEIS_SECOND_PCI_MASK) : BEIS_FLAG_MASK_DUAL;

   always_comb begin
      err_set = '0;
      // Each vector is ordered first PCI, second PCI, local DMA.
      err_set[BEIS_PB_RETRY_FIRST_BIT] = procbus_maxretry_in[0];
      err_set[BEIS_PB_RETRY_SECOND_BIT] = procbus_maxretry_in[1];
      err_set[BEIS_PB_RETRY_LOCAL_BIT] = procbus_maxretry_in[2];
      err_set[BEIS_PB_ERR_FIRST_BIT] = procbus_xfer_error_in[0];
      err_set[BEIS_PB_ERR_SECOND_BIT] = procbus_xfer_error_in[1];
      err_set[BEIS_PB_ERR_LOCAL_BIT] = procbus_xfer_error_in[2];
      err_set[BEIS_PB_APAR_BIT] = procbus_addr_parity_error_in;
      err_set[BEIS_PB_DPAR_FIRST_BIT] = procbus_data_parity_in[0];
      err_set[BEIS_PB_DPAR_SECOND_BIT] = procbus_data_parity_in[1];
      err_set[BEIS_PB_DPAR_LOCAL_BIT] = procbus_data_parity_in[2];
      // Byte order: to-other-PCI, to-procbus, local DMA, address parity, then retries.
      err_set[BEIS_SECOND_PCI_LSB+7 -: 3] = second_pci_error_in;
      err_set[BEIS_SECOND_PCI_LSB+4] = second_pci_addr_parity_error_in;
      err_set[BEIS_SECOND_PCI_LSB+3 -: 3] = second_pci_retry_in;
      err_set[BEIS_FIRST_PCI_LSB+7 -: 3] = first_pci_error_in;
      err_set[BEIS_FIRST_PCI_LSB+4] = first_pci_addr_parity_error_in;
      err_set[BEIS_FIRST_PCI_LSB+3 -: 3] = first_pci_retry_in;
   end

   // ==========================================================
   // APB access decode
   logic apb_write;
   logic apb_read;
   logic addr_err;
   logic addr_mask;
   logic addr_norm;
   logic [31:0] wr_bytes;

   assign addr_err = (paddr_in == BEIS_ERR_STATUS_OFF);
   assign addr_mask = (paddr_in == BEIS_ERR_MASK_OFF);
   assign addr_norm = (paddr_in == BEIS_NORM_STATUS_OFF);
   assign apb_write = psel_in & penable_in & pwrite_in;
   assign apb_read = psel_in & penable_in & ~pwrite_in;
   assign wr_bytes = pwdata_in & {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

   // Zeros written leave flags untouched.
   assign err_clear = (apb_write & addr_err) ? wr_bytes : 32'h00000000;
   assign norm_clear = (apb_write & addr_norm) ? wr_bytes : 32'h00000000;
   assign norm_set = normal_event_in & BEIS_NORM_FLAG_MASK;

   beis_flag_bank #(
      .WIDTH(32)
   ) u_err_flags (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .valid_in(err_valid),
      .set_in(err_set),
      .clear_in(err_clear),
      .flags_out(err_flags)
   );

   beis_flag_bank #(
      .WIDTH(32)
   ) u_norm_flags (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .valid_in(BEIS_NORM_FLAG_MASK),
      .set_in(norm_set),
      .clear_in(norm_clear),
      .flags_out(norm_flags)
   );

   // The summary follows the normal flags directly, so it clears with the last of them.
   assign normal_status_any_active = |norm_flags;

   // ==========================================================
   // Mask register and interrupt output
   logic [31:0] mask_ff;
   logic [31:0] nxt_mask;
   logic irq_ff;
   logic nxt_irq;
   logic [31:0] err_view;

   always_comb begin
      err_view = err_flags;
      err_view[BEIS_NORM_ACTIVE_BIT] = normal_status_any_active;
   end

   always_comb begin
      nxt_mask = mask_ff;
      if (apb_write & addr_mask) begin
         // Only real flag positions hold a mask bit.
         nxt_mask = ((mask_ff & ~{{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}})
                     | wr_bytes) & err_valid;
      end
      // Registered so the pin never glitches on set and clear in one cycle.
      nxt_irq = |(err_flags & mask_ff);
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mask_ff <= BEIS_RESET_VAL;
         irq_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         irq_ff <= nxt_irq;
      end
   end

   assign irq_out = irq_ff;

   // ==========================================================
   // Read data
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = rdata_ff;
      if (psel_in & ~penable_in & ~pwrite_in) begin
         if (paddr_in == BEIS_ERR_STATUS_OFF) begin
            nxt_rdata = err_view;
         end else if (paddr_in == BEIS_ERR_MASK_OFF) begin
            nxt_rdata = mask_ff;
         end else if (paddr_in == BEIS_NORM_STATUS_OFF) begin
            nxt_rdata = norm_flags;
         end else begin
            nxt_rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata_out = rdata_ff;
   assign pready_out = 1'b1;
   // Unmapped addresses answer with an error and change nothing.
   assign pslverr_out = (apb_write | apb_read) & ~(addr_err | addr_mask | addr_norm);

endmodule : beis_error_status
`default_nettype wire

// ===== bench/beis_error_status_asserts.sv
// Port-level checker for the bridge error interrupt status block.
`timescale 1ns/10ps
`default_nettype none
module beis_error_status_asserts
   import beis_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [31:0] normal_event_in,
   input wire logic [2:0] procbus_maxretry_in,
   input wire logic procbus_addr_parity_error_in,
   input wire logic second_pci_addr_parity_error_in,
   input wire logic first_pci_addr_parity_error_in
);
   // ==========================================================
   // Helpers and properties
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic acc;
   logic rd_setup;
   logic mapped;
   assign acc = psel_in && penable_in;
   assign rd_setup = psel_in && !penable_in && !pwrite_in && paddr_in == BEIS_ERR_STATUS_OFF;
   assign mapped = paddr_in inside {BEIS_ERR_STATUS_OFF, BEIS_ERR_MASK_OFF, BEIS_NORM_STATUS_OFF};
   a_unmapped_refused: assert property (acc && !mapped |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr_out && pready_out)
      else $error("mapped access refused");
   a_reserved_zero: assert property (acc && !pwrite_in && paddr_in == BEIS_ERR_STATUS_OFF |-> (prdata_out & 32'h71010101) == 32'h0)
      else $error("reserved bit reads one");
   a_rdata_hold: assert property (!(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
      else $error("read data moved without a read");
   a_pb_apar_seen: assert property (procbus_addr_parity_error_in ##1 rd_setup |=> prdata_out[20])
      else $error("address parity flag missing");
   a_p2_apar_seen: assert property (second_pci_addr_parity_error_in ##1 rd_setup |=> prdata_out[12])
      else $error("second port parity flag missing");
   a_p1_apar_seen: assert property (first_pci_addr_parity_error_in ##1 rd_setup |=> prdata_out[4])
      else $error("first port parity flag missing");
   a_summary_set: assert property (normal_event_in[0] ##1 rd_setup |=> prdata_out[31])
      else $error("summary bit missing");
   a_pb_retry_seen: assert property (procbus_maxretry_in[0] ##1 rd_setup |=> prdata_out[27])
      else $error("retry flag missing");
endmodule : beis_error_status_asserts
bind beis_error_status beis_error_status_asserts i_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .normal_event_in(normal_event_in), .procbus_maxretry_in(procbus_maxretry_in),
   .procbus_addr_parity_error_in(procbus_addr_parity_error_in),
   .second_pci_addr_parity_error_in(second_pci_addr_parity_error_in),
   .first_pci_addr_parity_error_in(first_pci_addr_parity_error_in));
`default_nettype wire

// ===== bench/beis_error_status_tb.sv
// Self-checking testbench for the bridge error interrupt status block.
`timescale 1ns/10ps
`default_nettype none
module beis_error_status_tb;
   import beis_pkg::*;
   // ==========================================================
   // Stimulus signals and design
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] pstrb_in = 4'hF;
   logic [31:0] prdata_s;
   logic [31:0] rs;
   logic [31:0] nev = 32'h0;
   logic [23:0] ev = 24'h0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic irq_out;
   logic [31:0] r;
   logic e;
   int failures = 0;
   int checks_done = 0;
   // Flag bit reached by each bit of the event vector.
   localparam int POS [24] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 19, 18, 17, 20, 23, 22, 21, 27, 26, 25};
   always #2 ref_clk_in = ~ref_clk_in;
   beis_error_status i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .normal_event_in(nev), .procbus_maxretry_in(ev[23:21]), .procbus_xfer_error_in(ev[20:18]),
      .procbus_addr_parity_error_in(ev[17]), .procbus_data_parity_in(ev[16:14]),
      .second_pci_error_in(ev[13:11]), .second_pci_addr_parity_error_in(ev[10]),
      .second_pci_retry_in(ev[9:7]), .first_pci_error_in(ev[6:4]),
      .first_pci_addr_parity_error_in(ev[3]), .first_pci_retry_in(ev[2:0]), .irq_out(irq_out));
   // Single-port variant on the same bus; its second-port parity pin stays low so the bound checker holds.
   beis_error_status #(.SINGLE_PCI(1'b1)) i_dut_single (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_s), .pready_out(), .pslverr_out(),
      .normal_event_in(nev), .procbus_maxretry_in(ev[23:21]), .procbus_xfer_error_in(ev[20:18]),
      .procbus_addr_parity_error_in(ev[17]), .procbus_data_parity_in(ev[16:14]),
      .second_pci_error_in(ev[13:11]), .second_pci_addr_parity_error_in(1'b0),
      .second_pci_retry_in(ev[9:7]), .first_pci_error_in(ev[6:4]),
      .first_pci_addr_parity_error_in(ev[3]), .first_pci_retry_in(ev[2:0]), .irq_out());
   // ==========================================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // The master waits as long as the slave needs; only the watchdog ends a stuck transfer.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge ref_clk_in);
      end while (pready_out !== 1'b1);
      r = prdata_out;
      rs = prdata_s;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("read data", x, r);
   endtask : rd
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #20000;
      failures++;
      wrap_up();
   end
   // ==========================================================
   // Tests
   initial begin
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge ref_clk_in);
      rd(BEIS_ERR_STATUS_OFF, 32'h0);
      rd(BEIS_ERR_MASK_OFF, 32'h0);
      for (int i = 0; i < 24; i++) begin
         ev[i] <= 1'b1;
         @(posedge ref_clk_in);
         ev <= 24'h0;
         rd(BEIS_ERR_STATUS_OFF, 32'h1 << POS[i]);
         apb(1'b1, BEIS_ERR_STATUS_OFF, 32'h0);
         rd(BEIS_ERR_STATUS_OFF, 32'h1 << POS[i]);
         apb(1'b1, BEIS_ERR_STATUS_OFF, 32'h1 << POS[i]);
         rd(BEIS_ERR_STATUS_OFF, 32'h0);
      end
      ev <= 24'hFFFFFF;
      @(posedge ref_clk_in);
      ev <= 24'h0;
      rd(BEIS_ERR_STATUS_OFF, 32'h0EFEFEFE);
      chk("single variant read", 32'h0ABA0076, rs);
      apb(1'b1, BEIS_ERR_STATUS_OFF, 32'hFFFFFFFF);
      rd(BEIS_ERR_STATUS_OFF, 32'h0);
      nev <= 32'h1;
      @(posedge ref_clk_in);
      nev <= 32'h0;
      rd(BEIS_ERR_STATUS_OFF, 32'h80000000);
      rd(BEIS_NORM_STATUS_OFF, 32'h00000001);
      apb(1'b1, BEIS_ERR_STATUS_OFF, 32'hFFFFFFFF);
      rd(BEIS_ERR_STATUS_OFF, 32'h80000000);
      apb(1'b1, BEIS_NORM_STATUS_OFF, 32'h1);
      rd(BEIS_ERR_STATUS_OFF, 32'h0);
      // The event is seen only at the edge that takes the clearing write.
      fork
         apb(1'b1, BEIS_ERR_STATUS_OFF, 32'h00100000);
         begin
            @(posedge ref_clk_in);
            ev[17] <= 1'b1;
            @(posedge ref_clk_in);
            ev[17] <= 1'b0;
         end
      join
      rd(BEIS_ERR_STATUS_OFF, 32'h00100000);
      pstrb_in <= 4'hB;
      apb(1'b1, BEIS_ERR_STATUS_OFF, 32'h00100000);
      pstrb_in <= 4'hF;
      rd(BEIS_ERR_STATUS_OFF, 32'h00100000);
      apb(1'b1, BEIS_ERR_MASK_OFF, 32'h00100000);
      rd(BEIS_ERR_MASK_OFF, 32'h00100000);
      chk("irq", 32'h1, {31'h0, irq_out});
      apb(1'b1, BEIS_ERR_MASK_OFF, 32'h0);
      rd(BEIS_ERR_STATUS_OFF, 32'h00100000);
      chk("irq", 32'h0, {31'h0, irq_out});
      apb(1'b1, BEIS_ERR_MASK_OFF, 32'h00100000);
      apb(1'b1, BEIS_ERR_STATUS_OFF, 32'h00100000);
      rd(BEIS_ERR_STATUS_OFF, 32'h0);
      chk("irq", 32'h0, {31'h0, irq_out});
      ev <= 24'hFFFFFF;
      nev <= 32'h1;
      @(posedge ref_clk_in);
      ev <= 24'h0;
      nev <= 32'h0;
      apb(1'b1, BEIS_ERR_MASK_OFF, 32'hFFFFFFFF);
      rd(BEIS_ERR_MASK_OFF, 32'h0EFEFEFE);
      chk("irq", 32'h1, {31'h0, irq_out});
      sys_rst_in <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge ref_clk_in);
      rd(BEIS_ERR_STATUS_OFF, 32'h0);
      rd(BEIS_ERR_MASK_OFF, 32'h0);
      rd(BEIS_NORM_STATUS_OFF, 32'h0);
      chk("irq", 32'h0, {31'h0, irq_out});
      rd(12'h7FC, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      wrap_up();
   end
endmodule : beis_error_status_tb
`default_nettype wire
